/* flash_protection_config_defines.svh */
/*
 * Offsets, field positions, reset values and address bounds of the
 * flash range protection block.
 * Assumes inclusion by bare name from the modules.
 */
`ifndef FLASH_PROTECTION_CONFIG_DEFINES_SVH
`define FLASH_PROTECTION_CONFIG_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_PROT_CONFIG     12'h004
`define OFS_FLASH_STATUS    12'h005
`define OFS_IRQ_STATUS      12'h010
`define OFS_IRQ_MASK        12'h014

// ---------------------------------------------------------------
// Field positions of flash_protection_config
// ---------------------------------------------------------------
`define POS_POLARITY        7
`define POS_SPARE_NV        6
`define POS_HIGH_OFF        5
`define POS_HIGH_SIZE_HI    4
`define POS_HIGH_SIZE_LO    3
`define POS_LOW_OFF         2
`define POS_LOW_SIZE_HI     1
`define POS_LOW_SIZE_LO     0

// ---------------------------------------------------------------
// Field positions of flash_status and interrupt registers
// ---------------------------------------------------------------
`define POS_VIOLATION       5
`define POS_IRQ_VIOL        0
`define POS_IRQ_LOADED      1

// ---------------------------------------------------------------
// Reset values and load address
// ---------------------------------------------------------------
`define RST_PROT_CONFIG     8'hff
`define PROT_BYTE_ADDR      16'hff0d
`define RST_IRQ_MASK        2'h0

// ---------------------------------------------------------------
// Range bounds
// ---------------------------------------------------------------
`define HIGH_END            16'hffff
`define HIGH_START_0        16'hf800
`define HIGH_START_1        16'hf000
`define HIGH_START_2        16'he000
`define HIGH_START_3        16'hc000
`define LOW_START           16'h4000
`define LOW_END_0           16'h41ff
`define LOW_END_1           16'h43ff
`define LOW_END_2           16'h47ff
`define LOW_END_3           16'h4fff

`endif

/* flash_protection_config_pkg.sv */
/*
 * Types of the flash range protection block.
 * Assumes the defines header sits in the same folder.
 */
package flash_protection_config_pkg;

  typedef enum logic [1:0] {
    LOAD_REQ  = 2'b00,
    LOAD_WAIT = 2'b01,
    RUNNING   = 2'b10
  } load_state_t;

  typedef enum logic [1:0] {
    CMD_PROGRAM    = 2'b00,
    CMD_ERASE      = 2'b01,
    CMD_MASS_ERASE = 2'b10,
    CMD_OTHER      = 2'b11
  } flash_cmd_t;

endpackage

/* prot_cfg_if.sv */
/*
 * Carries the live protection setting from the register file to the
 * range checker.
 * Assumes both ends share core_clk_i.
 */
`timescale 1ns/100ps
interface prot_cfg_if;
  logic [7:0] cfg;

  modport source (output cfg);
  modport sink   (input  cfg);
endinterface // prot_cfg_if

/* range_match.sv */
/*
 * One address range compare, size chosen by a two bit code.
 * Assumes bounds come in as four start and four end constants.
 */
`timescale 1ns/100ps
module range_match #(
  parameter logic [63:0] STARTS = 64'h0000_0000_0000_0000,
  parameter logic [63:0] ENDS   = 64'h0000_0000_0000_0000
) (
  input  wire logic [15:0] addr_i,
  input  wire logic [1:0]  size_i,
  output logic             hit_o
);
  logic [15:0] lo_b;
  logic [15:0] hi_b;

  always_comb begin
    lo_b  = STARTS[16*size_i +: 16];
    hi_b  = ENDS[16*size_i +: 16];
    hit_o = (addr_i >= lo_b) && (addr_i <= hi_b);
  end
endmodule // range_match

/* prot_check.sv */
/*
 * Decides whether a command target address is protected.
 * Assumes the setting arrives over prot_cfg_if, same clock.
 */
`timescale 1ns/100ps
`include "flash_protection_config_defines.svh"
module prot_check (
  prot_cfg_if.sink         cfg_if,
  input  wire logic [15:0] addr_i,
  output logic             prot_o,
  output logic             all_open_o
);
  logic high_hit;
  logic low_hit;
  logic pol;
  logic h_off;
  logic l_off;
  logic in_area;

  range_match #(
    .STARTS({`HIGH_START_3, `HIGH_START_2, `HIGH_START_1, `HIGH_START_0}),
    .ENDS  ({`HIGH_END, `HIGH_END, `HIGH_END, `HIGH_END})
  ) u_high (
    .addr_i(addr_i),
    .size_i(cfg_if.cfg[`POS_HIGH_SIZE_HI:`POS_HIGH_SIZE_LO]),
    .hit_o (high_hit)
  );

  range_match #(
    .STARTS({`LOW_START, `LOW_START, `LOW_START, `LOW_START}),
    .ENDS  ({`LOW_END_3, `LOW_END_2, `LOW_END_1, `LOW_END_0})
  ) u_low (
    .addr_i(addr_i),
    .size_i(cfg_if.cfg[`POS_LOW_SIZE_HI:`POS_LOW_SIZE_LO]),
    .hit_o (low_hit)
  );

  always_comb begin
    pol     = cfg_if.cfg[`POS_POLARITY];
    h_off   = cfg_if.cfg[`POS_HIGH_OFF];
    l_off   = cfg_if.cfg[`POS_LOW_OFF];
    in_area = (high_hit && !h_off) || (low_hit && !l_off);
    // Inside an enabled range: protected or open by polarity
    prot_o  = pol ? in_area : !in_area;
    all_open_o = pol && h_off && l_off;
  end
endmodule // prot_check

/* flash_range_protection.sv */
/*
 * Flash range protection: register file on AXI4-Lite, reset-time load
 * of the protection byte, target check and violation flag.
 * Assumes a flash read port for the load and a command controller that
 * offers one command at a time and waits for launch or refusal.
 */
`timescale 1ns/100ps
`include "flash_protection_config_defines.svh"

module flash_range_protection
  import flash_protection_config_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Reset-time load from the flash array
  output logic             nv_rd_req_o,
  output logic [15:0]      nv_rd_addr_o,
  input  wire logic        nv_rd_valid_i,
  input  wire logic [7:0]  nv_rd_data_i,
  // Command controller
  input  wire logic        cmd_valid_i,
  input  wire flash_cmd_t  cmd_i,
  input  wire logic [15:0] cmd_addr_i,
  output logic             cmd_launch_o,
  output logic             cmd_refuse_o,
  output logic             load_done_o,
  output logic             violation_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  load_state_t ld_r,     ld_nxt;
  logic [7:0]  cfg_r,    cfg_nxt;
  logic        viol_r,   viol_nxt;
  logic [1:0]  ists_r,   ists_nxt;
  logic [1:0]  imask_r,  imask_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic        aw_have_r, aw_have_nxt;
  logic [31:0] wdata_r,  wdata_nxt;
  logic [3:0]  wstrb_r,  wstrb_nxt;
  logic        w_have_r, w_have_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r,  bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  logic [1:0]  rresp_r,  rresp_nxt;

  logic        prot_hit;
  logic        all_open;
  logic        do_write;
  logic [7:0]  cand;
  logic        viol_set;
  logic        allowed;

  // Status byte lives in lane one of the config word
  localparam int STAT_LANE = `OFS_FLASH_STATUS % 4;
  localparam int STAT_BIT  = 8 * STAT_LANE + `POS_VIOLATION;

  prot_cfg_if cfg_bus ();
  assign cfg_bus.cfg = cfg_r;

  prot_check u_check (
    .cfg_if    (cfg_bus),
    .addr_i    (cmd_addr_i),
    .prot_o    (prot_hit),
    .all_open_o(all_open)
  );

  // ---------------------------------------------------------------
  // Scenario transition table
  // ---------------------------------------------------------------
  // Scenario code is polarity, high off, low off read as a number
  function automatic logic [2:0] scen(input logic [7:0] v);
    scen = {v[`POS_POLARITY], v[`POS_HIGH_OFF], v[`POS_LOW_OFF]};
  endfunction

  // Columns in bit order: bit n set if move to scenario n is allowed
  function automatic logic allowed_move(input logic [2:0] f,
                                        input logic [2:0] t);
    logic [7:0] row;
    row = 8'h00;
    unique case (f)
      3'd0: row = 8'h0f;
      3'd1: row = 8'h0a;
      3'd2: row = 8'h0c;
      3'd3: row = 8'h08;
      3'd4: row = 8'h18;
      3'd5: row = 8'h3c;
      3'd6: row = 8'h5a;
      3'd7: row = 8'hff;
    endcase
    allowed_move = row[t];
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    ld_nxt      = ld_r;
    cfg_nxt     = cfg_r;
    viol_nxt    = viol_r;
    ists_nxt    = ists_r;
    imask_nxt   = imask_r;
    awaddr_nxt  = awaddr_r;
    aw_have_nxt = aw_have_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    w_have_nxt  = w_have_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    cand        = cfg_r;
    viol_set    = 1'b0;
    allowed     = 1'b0;

    unique case (ld_r)
      LOAD_REQ:  ld_nxt = LOAD_WAIT;
      LOAD_WAIT: if (nv_rd_valid_i) begin
        cfg_nxt = nv_rd_data_i;
        ld_nxt  = RUNNING;
      end
      RUNNING:   ld_nxt = RUNNING;
      default:   ld_nxt = LOAD_REQ;
    endcase

    // Check precedes launch, so a refused command never touches flash
    if (cmd_valid_i && ld_r == RUNNING && !viol_r) begin
      if (cmd_i == CMD_MASS_ERASE) begin
        viol_set = !all_open;
      end else if (cmd_i != CMD_OTHER) begin
        viol_set = prot_hit;
      end
    end

    // AXI write channels taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt  = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    do_write = aw_have_r && w_have_r && !bvalid_r;
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = 2'b00;
      unique case (awaddr_r[11:2])
        10'(`OFS_PROT_CONFIG >> 2): begin
          // Lane 0 holds the register, lane 1 the status byte
          if (wstrb_r[STAT_LANE] && wdata_r[STAT_BIT]) begin
            viol_nxt = 1'b0;
          end
          if (wstrb_r[0]) begin
            cand = wdata_r[7:0];
            if (cfg_r[`POS_POLARITY] == 1'b0) begin
              cand[`POS_POLARITY] = 1'b0;
            end
            if (!cfg_r[`POS_LOW_OFF]) begin
              cand[`POS_LOW_SIZE_HI:`POS_LOW_SIZE_LO] =
                cfg_r[`POS_LOW_SIZE_HI:`POS_LOW_SIZE_LO];
            end
            if (!cfg_r[`POS_HIGH_OFF]) begin
              cand[`POS_HIGH_SIZE_HI:`POS_HIGH_SIZE_LO] =
                cfg_r[`POS_HIGH_SIZE_HI:`POS_HIGH_SIZE_LO];
            end
            allowed = allowed_move(scen(cfg_r), scen(cand));
            if (allowed && ld_r == RUNNING) begin
              cfg_nxt = cand;
            end
          end
        end
        10'(`OFS_IRQ_STATUS >> 2): begin
          if (wstrb_r[0]) begin
            ists_nxt = ists_r & ~wdata_r[1:0];
          end
        end
        10'(`OFS_IRQ_MASK >> 2): begin
          if (wstrb_r[0]) begin
            imask_nxt = wdata_r[1:0];
          end
        end
        default: bresp_nxt = 2'b10;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end

    // Hardware set wins over a same-cycle clear
    if (ld_r == LOAD_WAIT && nv_rd_valid_i) begin
      ists_nxt[`POS_IRQ_LOADED] = 1'b1;
    end
    if (viol_set) begin
      viol_nxt = 1'b1;
      ists_nxt[`POS_IRQ_VIOL] = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'b00;
      rdata_nxt  = 32'h0000_0000;
      unique case (s_axi_araddr[11:2])
        10'(`OFS_PROT_CONFIG >> 2): begin
          rdata_nxt[7:0]      = cfg_r;
          rdata_nxt[STAT_BIT] = viol_r;
        end
        10'(`OFS_IRQ_STATUS >> 2):   rdata_nxt[1:0] = ists_r;
        10'(`OFS_IRQ_MASK >> 2):     rdata_nxt[1:0] = imask_r;
        default:                     rresp_nxt = 2'b10;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ld_r      <= LOAD_REQ;
      cfg_r     <= `RST_PROT_CONFIG;
      viol_r    <= 1'b0;
      ists_r    <= 2'h0;
      imask_r   <= `RST_IRQ_MASK;
      awaddr_r  <= 12'h000;
      aw_have_r <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'b00;
    end else begin
      ld_r      <= ld_nxt;
      cfg_r     <= cfg_nxt;
      viol_r    <= viol_nxt;
      ists_r    <= ists_nxt;
      imask_r   <= imask_nxt;
      awaddr_r  <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      w_have_r  <= w_have_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    s_axi_awready = !aw_have_r;
    s_axi_wready  = !w_have_r;
    s_axi_bvalid  = bvalid_r;
    s_axi_bresp   = bresp_r;
    s_axi_arready = !rvalid_r;
    s_axi_rvalid  = rvalid_r;
    s_axi_rdata   = rdata_r;
    s_axi_rresp   = rresp_r;
    nv_rd_req_o   = (ld_r == LOAD_REQ) || (ld_r == LOAD_WAIT);
    nv_rd_addr_o  = `PROT_BYTE_ADDR;
    load_done_o   = (ld_r == RUNNING);
    // Refuse while flag set or while this command trips it
    cmd_refuse_o  = cmd_valid_i && (viol_r || viol_set);
    cmd_launch_o  = cmd_valid_i && (ld_r == RUNNING)
                    && !viol_r && !viol_set;
    violation_o   = viol_r;
    irq_o         = |(ists_r & imask_r);
  end

endmodule // flash_range_protection

/* flash_range_protection_chk.sv */
/*
 * Port checker of the flash range protection block.
 * Assumes binding to flash_range_protection, one clock, async reset.
 */
`timescale 1ns/100ps
module flash_range_protection_chk
  import flash_protection_config_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        nv_rd_req_o,
  input  wire logic [15:0] nv_rd_addr_o,
  input  wire logic        nv_rd_valid_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_launch_o,
  input  wire logic        cmd_refuse_o,
  input  wire logic        load_done_o,
  input  wire logic        violation_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence new_refusal;
    cmd_refuse_o && !violation_o;
  endsequence

  sequence flag_raised;
    violation_o;
  endsequence

  a_load_addr: assert property (
    nv_rd_req_o |-> nv_rd_addr_o == 16'hff0d)
    else $error("Load address wrong");
  a_load_needs_data: assert property (
    $rose(load_done_o) |-> $past(nv_rd_valid_i))
    else $error("Load finished without flash data");
  a_load_ends_req: assert property (
    load_done_o |-> !nv_rd_req_o)
    else $error("Load request after load");
  a_no_early_cmd: assert property (
    !load_done_o |-> !cmd_launch_o && !cmd_refuse_o)
    else $error("Command answered before load");
  a_refusal_flags: assert property (
    new_refusal |=> flag_raised)
    else $error("Refusal did not raise the flag");
  // Writes take two edges to land, so three samples of wvalid
  a_flag_sticky: assert property (
    violation_o && !s_axi_wvalid && !$past(s_axi_wvalid)
      && !$past(s_axi_wvalid, 2) |=> violation_o)
    else $error("Flag dropped without a write");
  a_flag_blocks: assert property (
    violation_o && cmd_valid_i |-> cmd_refuse_o && !cmd_launch_o)
    else $error("Command launched while flag set");
  a_launch_clean: assert property (
    cmd_launch_o |-> cmd_valid_i && !cmd_refuse_o && !violation_o)
    else $error("Launch together with refusal");
  a_cfg_readable: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered");
endmodule // flash_range_protection_chk

bind flash_range_protection flash_range_protection_chk chk_u (
  .core_clk_i, .arst_n_i, .s_axi_wvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .nv_rd_req_o, .nv_rd_addr_o, .nv_rd_valid_i,
  .cmd_valid_i, .cmd_launch_o, .cmd_refuse_o, .load_done_o, .violation_o
);

/* testbench.sv */
/*
 * Self-checking bench of the flash range protection block.
 * Assumes the design files and the bound checker are compiled first.
 */
`timescale 1ns/100ps
module testbench;
  import flash_protection_config_pkg::*;
  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  logic        core_clk_i, arst_n_i, s_axi_awvalid, s_axi_wvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_rready, nv_rd_valid_i;
  logic        cmd_valid_i, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, nv_rd_req_o, cmd_launch_o;
  logic        cmd_refuse_o, load_done_o, violation_o, irq_o;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] nv_rd_addr_o, cmd_addr_i;
  logic [7:0]  nv_rd_data_i;
  flash_cmd_t  cmd_i;
  int          fails, num_checks, cycles;
  logic [7:0]  wv [9] = '{8'hfd, 8'hf9, 8'hfa, 8'hfd, 8'he9, 8'hc1,
                          8'h69, 8'h6d, 8'hed};
  logic [7:0]  rv [9] = '{8'hfd, 8'hf9, 8'hf9, 8'hf9, 8'he9, 8'hc1,
                          8'hc1, 8'h65, 8'h6d};
  logic [7:0]  ph_cfg [11] = '{8'hc4, 8'hcc, 8'hd4, 8'hdc, 8'he0, 8'he1,
                               8'he2, 8'he3, 8'h5c, 8'h60, 8'hfb};
  logic [15:0] ph_open [11] = '{16'hf7ff, 16'hefff, 16'hdfff, 16'hbfff,
    16'h4200, 16'h4400, 16'h4800, 16'h5000, 16'hc000, 16'h4000, 16'h5000};
  logic [15:0] ph_prot [11] = '{16'hf800, 16'hf000, 16'he000, 16'hc000,
    16'h41ff, 16'h43ff, 16'h47ff, 16'h4fff, 16'hbfff, 16'h3fff, 16'h0000};

  flash_range_protection dut_u (
    .core_clk_i, .arst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .nv_rd_req_o, .nv_rd_addr_o, .nv_rd_valid_i,
    .nv_rd_data_i, .cmd_valid_i, .cmd_i, .cmd_addr_i, .cmd_launch_o,
    .cmd_refuse_o, .load_done_o, .violation_o, .irq_o
  );

  always #2.5 core_clk_i = ~core_clk_i;

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input bit wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q, output logic [1:0] r);
    int   n;
    logic aw, w, ar, b;
    @(posedge core_clk_i);
    if (wr) begin
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
    end
    b = 1'b0;
    for (n = 0; n < 40 && !b; n++) begin
      #1;
      aw = s_axi_awvalid & s_axi_awready;
      w  = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      b  = wr ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
      q  = s_axi_rdata;
      r  = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge core_clk_i);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk(b, 1'b1);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, s, q, r);
    chk(r, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 32'h0000_0000, 4'h0, q, r);
    chk(q, exp);
    chk(r, er);
  endtask

  task automatic probe(input flash_cmd_t c, input logic [15:0] a,
                       input logic l, input logic f);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= c;
    cmd_addr_i  <= a;
    #1;
    chk(cmd_launch_o, l);
    chk(cmd_refuse_o, f);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic [7:0] nv);
    int n;
    @(posedge core_clk_i);
    arst_n_i      <= 1'b0;
    nv_rd_data_i  <= nv;
    nv_rd_valid_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    #1;
    chk(nv_rd_req_o, 1'b1);
    chk(nv_rd_addr_o, 16'hff0d);
    @(posedge core_clk_i);
    nv_rd_valid_i <= 1'b1;
    for (n = 0; n < 20 && load_done_o !== 1'b1; n++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk(load_done_o, 1'b1);
    chk(violation_o, 1'b0);
    @(posedge core_clk_i);
    nv_rd_valid_i <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    {core_clk_i, arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, nv_rd_valid_i, cmd_valid_i} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {nv_rd_data_i, cmd_addr_i, fails, num_checks, cycles} = '0;
    cmd_i = CMD_PROGRAM;
    do_reset(8'hfe);
    rd(12'h004, 32'h0000_00fe, 2'b00);
    probe(CMD_MASS_ERASE, 16'h8000, 1'b1, 1'b0);
    probe(CMD_PROGRAM, 16'hff0d, 1'b1, 1'b0);
    for (int i = 0; i < 9; i++) begin
      wr(12'h004, 32'(wv[i]), 4'h1, 2'b00);
      rd(12'h004, 32'(rv[i]), 2'b00);
    end
    probe(CMD_OTHER, 16'h8000, 1'b1, 1'b0);
    probe(CMD_PROGRAM, 16'h8000, 1'b0, 1'b1);
    chk(violation_o, 1'b1);
    rd(12'h004, 32'h0000_206d, 2'b00);
    rd(12'h010, 32'h0000_0003, 2'b00);
    chk(irq_o, 1'b0);
    wr(12'h014, 32'h0000_0001, 4'h1, 2'b00);
    chk(irq_o, 1'b1);
    wr(12'h010, 32'h0000_0001, 4'h1, 2'b00);
    chk(irq_o, 1'b0);
    rd(12'h010, 32'h0000_0002, 2'b00);
    wr(12'h020, 32'hffff_ffff, 4'hf, 2'b10);
    rd(12'h020, 32'h0000_0000, 2'b10);
    // Status byte sits in lane one of the config word
    wr(12'h004, 32'h0000_0000, 4'h2, 2'b00);
    chk(violation_o, 1'b1);
    wr(12'h004, 32'h0000_2000, 4'h2, 2'b00);
    chk(violation_o, 1'b0);
    // A write cannot set polarity again or resize an enabled range, so each case reloads by reset
    for (int i = 0; i < 11; i++) begin
      do_reset(ph_cfg[i]);
      probe(CMD_PROGRAM, ph_open[i], 1'b1, 1'b0);
      probe(i == 10 ? CMD_MASS_ERASE : (i[0] ? CMD_ERASE : CMD_PROGRAM),
            ph_prot[i], 1'b0, 1'b1);
      chk(violation_o, 1'b1);
      probe(CMD_PROGRAM, ph_open[i], 1'b0, 1'b1);
    end
    summarize();
  end
endmodule // testbench
